/* File: rtl/incu_pkg.sv */
// shared constants and carriers for the increment execution unit
package incu_pkg;

   // machine cycle length in core clocks and per-form cycle counts
   localparam int INCU_MCYC_CLKS = 12;
   localparam int INCU_MCYC_BYTE = 1;
   localparam int INCU_MCYC_DATA_POINTER = 2;

   // opcode encodings
   localparam logic [7:0] INCU_OP_ACC = 8'h04;
   localparam logic [7:0] INCU_OP_DIR = 8'h05;
   localparam logic [6:0] INCU_OP_IND_HI = 7'h03;
   localparam logic [4:0] INCU_OP_RN_HI = 5'h01;
   localparam logic [7:0] INCU_OP_DATA_POINTER = 8'hA3;

   // direct address space: below this is internal ram, above are special registers
   localparam logic [7:0] INCU_SFR_BASE = 8'h80;
   localparam logic [7:0] INCU_ADR_ACC = 8'hE0;
   localparam logic [7:0] INCU_ADR_DPL = 8'h82;
   localparam logic [7:0] INCU_ADR_DPH = 8'h83;
   localparam logic [7:0] INCU_ADR_PORT0 = 8'h80;
   localparam logic [7:0] INCU_ADR_PORT1 = 8'h90;
   localparam logic [7:0] INCU_ADR_PORT2 = 8'hA0;
   localparam logic [7:0] INCU_ADR_PORT3 = 8'hB0;

   // reset values
   localparam logic [7:0] INCU_RST_BYTE = 8'h00;
   localparam logic [7:0] INCU_RST_PORT = 8'hFF;

   typedef enum logic [2:0] {
      K_NONE, K_ACC, K_RN, K_DIR, K_IND, K_DATA_POINTER
   } incu_kind_e;

   // instruction handed over by the core: opcode, second byte, register bank
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] operand;
      logic [1:0] bank;
   } incu_cmd_s;

   // architectural state held by the unit
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] pointer_high_byte;
      logic [7:0] pointer_low_byte;
      logic [3:0][7:0] port_latch;
   } incu_arch_s;

   // opcode decode, shared by the sequencer and its checks
   function automatic incu_kind_e incu_decode(input logic [7:0] op);
      if (op == INCU_OP_ACC) return K_ACC;
      if (op == INCU_OP_DIR) return K_DIR;
      if (op == INCU_OP_DATA_POINTER) return K_DATA_POINTER;
      if (op[7:1] == INCU_OP_IND_HI) return K_IND;
      if (op[7:3] == INCU_OP_RN_HI) return K_RN;
      return K_NONE;
   endfunction

endpackage

/* File: rtl/incu_ram.sv */
`timescale 1ns/1ps
// internal data ram: one write port, one registered read port
module incu_ram #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // write port
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   // read port
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [2**AW];

   // array is not reset; contents are undefined until written
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // read is old-data on a same-address write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule // incu_ram

/* File: rtl/incu_unit.sv */
// Function
// RULE1: byte forms add one, one machine cycle
// RULE2: byte wraps 0FFH to 00H, flags untouched
// RULE3: port operand read from latch, written back
// RULE4: opcode 00001rrr increments bank working register
// RULE5: opcode 00000101 plus direct address byte
// RULE6: opcode 0000011i increments ram via pointer register
// RULE7: data pointer adds one modulo 65536
// RULE8: low byte wrap carries into high byte
// RULE9: only the data pointer increments as 16-bit
// RULE10: data pointer form: one byte, two cycles
// RULE11: accumulator 0x04, data pointer 0xA3
`timescale 1ns/1ps
module incu_unit #(
   parameter int MCYC_CLKS = incu_pkg::INCU_MCYC_CLKS
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // instruction issue
   input wire logic CMD_VALID_I,
   input incu_pkg::incu_cmd_s CMD_I,
   output logic CMD_READY_O,
   output logic DONE_O,
   output logic REJECT_O,
   // preload and observation while idle
   input wire logic LD_VALID_I,
   input wire logic [7:0] LD_ADDR_I,
   input wire logic [7:0] LD_DATA_I,
   input wire logic [7:0] PEEK_ADDR_I,
   output logic [7:0] PEEK_DATA_O,
   output incu_pkg::incu_arch_s ARCH_O
);
   import incu_pkg::*;

   typedef enum logic {S_IDLE, S_EXEC} incu_state_e;

   localparam logic [7:0] LAST_BYTE = 8'(INCU_MCYC_BYTE * MCYC_CLKS - 1);
   localparam logic [7:0] LAST_DATA_POINTER = 8'(INCU_MCYC_DATA_POINTER * MCYC_CLKS - 1);
   localparam logic [7:0] STEP_PTR = 8'h01;
   localparam logic [7:0] STEP_WB = 8'h02;

   ////////////////////////////////////////////////////////////////////////////
   // special register access by direct address
   function automatic logic [7:0] sfr_read(input incu_arch_s a, input logic [7:0] adr);
      unique case (adr)
         INCU_ADR_ACC: return a.acc;
         INCU_ADR_DPL: return a.pointer_low_byte;
         INCU_ADR_DPH: return a.pointer_high_byte;
         INCU_ADR_PORT0: return a.port_latch[0];
         INCU_ADR_PORT1: return a.port_latch[1];
         INCU_ADR_PORT2: return a.port_latch[2];
         INCU_ADR_PORT3: return a.port_latch[3];
         default: return INCU_RST_BYTE;
      endcase
   endfunction

   function automatic incu_arch_s sfr_write(input incu_arch_s a, input logic [7:0] adr,
                                            input logic [7:0] d);
      incu_arch_s r;
      r = a;
      unique case (adr)
         INCU_ADR_ACC: r.acc = d;
         INCU_ADR_DPL: r.pointer_low_byte = d;
         INCU_ADR_DPH: r.pointer_high_byte = d;
         INCU_ADR_PORT0: r.port_latch[0] = d;
         INCU_ADR_PORT1: r.port_latch[1] = d;
         INCU_ADR_PORT2: r.port_latch[2] = d;
         INCU_ADR_PORT3: r.port_latch[3] = d;
         default: r = a;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   incu_state_e state_reg, state_next;
   incu_kind_e kind_reg, kind_next;
   incu_cmd_s cmd_reg, cmd_next;
   incu_arch_s arch_reg, arch_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [7:0] last_reg, last_next;
   logic [7:0] tgt_reg, tgt_next;
   logic ready_reg, ready_next;
   logic done_reg, done_next;
   logic reject_reg, reject_next;
   logic mem_we;
   logic [7:0] mem_waddr, mem_wdata, mem_raddr, mem_rdata;
   logic [7:0] fixed_addr, old_val;
   logic [15:0] data_pointer_inc;

   incu_ram #(.AW(8), .DW(8)) u_ram (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(mem_wdata),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   // first ram address of each form; working and pointer registers sit in the bank
   always_comb begin
      unique case (kind_reg)
         K_RN: fixed_addr = {3'h0, cmd_reg.bank, cmd_reg.opcode[2:0]}; // RULE4
         K_IND: fixed_addr = {3'h0, cmd_reg.bank, 2'h0, cmd_reg.opcode[0]}; // RULE6
         default: fixed_addr = cmd_reg.operand; // RULE5
      endcase
   end

   // read address: peek while idle, pointer then target while executing
   always_comb begin
      if (state_reg == S_IDLE) begin
         mem_raddr = PEEK_ADDR_I;
      end else if (cnt_reg == STEP_PTR && kind_reg == K_IND) begin
         mem_raddr = mem_rdata; // RULE6
      end else begin
         mem_raddr = fixed_addr;
      end
   end

   // starting value; ports come from the output latch, never the pins
   always_comb begin
      unique case (kind_reg)
         K_ACC: old_val = arch_reg.acc;
         K_DIR: old_val = (cmd_reg.operand >= INCU_SFR_BASE) ?
                          sfr_read(arch_reg, cmd_reg.operand) : mem_rdata; // RULE3
         default: old_val = mem_rdata;
      endcase
   end

   // 16-bit add so a low-byte wrap carries straight into the high byte
   assign data_pointer_inc = {arch_reg.pointer_high_byte, arch_reg.pointer_low_byte} + 16'h0001; // RULE7 RULE8

   ////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb begin
      state_next = state_reg;
      kind_next = kind_reg;
      cmd_next = cmd_reg;
      arch_next = arch_reg;
      cnt_next = cnt_reg;
      last_next = last_reg;
      tgt_next = tgt_reg;
      ready_next = ready_reg;
      done_next = 1'b0;
      reject_next = 1'b0;
      mem_we = 1'b0;
      mem_waddr = LD_ADDR_I;
      mem_wdata = LD_DATA_I;
      unique case (state_reg)
         S_IDLE: begin
            if (CMD_VALID_I) begin
               if (incu_decode(CMD_I.opcode) == K_NONE) begin
                  reject_next = 1'b1; // RULE9
               end else begin
                  kind_next = incu_decode(CMD_I.opcode); // RULE11
                  cmd_next = CMD_I;
                  cnt_next = '0;
                  last_next = (incu_decode(CMD_I.opcode) == K_DATA_POINTER) ?
                              LAST_DATA_POINTER : LAST_BYTE; // RULE1 RULE10
                  state_next = S_EXEC;
                  ready_next = 1'b0;
               end
            end else if (LD_VALID_I) begin
               if (LD_ADDR_I >= INCU_SFR_BASE) begin
                  arch_next = sfr_write(arch_reg, LD_ADDR_I, LD_DATA_I);
               end else begin
                  mem_we = 1'b1;
               end
            end
         end
         S_EXEC: begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == STEP_PTR) begin
               tgt_next = mem_raddr;
            end
            // write back; byte add wraps in 8 bits and no flag is touched
            if (cnt_reg == STEP_WB) begin
               mem_waddr = tgt_reg;
               mem_wdata = old_val + 8'h01; // RULE2
               unique case (kind_reg)
                  K_ACC: arch_next.acc = mem_wdata; // RULE1
                  K_RN, K_IND: mem_we = 1'b1; // RULE1
                  K_DIR: begin
                     if (cmd_reg.operand >= INCU_SFR_BASE) begin
                        arch_next = sfr_write(arch_reg, cmd_reg.operand, mem_wdata); // RULE3
                     end else begin
                        mem_we = 1'b1;
                     end
                  end
                  K_DATA_POINTER: begin
                     arch_next.pointer_high_byte = data_pointer_inc[15:8]; // RULE8
                     arch_next.pointer_low_byte = data_pointer_inc[7:0]; // RULE7
                  end
                  default: mem_we = 1'b0;
               endcase
            end
            if (cnt_reg == last_reg) begin
               state_next = S_IDLE;
               ready_next = 1'b1;
               done_next = 1'b1;
            end
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg <= S_IDLE;
         kind_reg <= K_NONE;
         cmd_reg <= '0;
         arch_reg <= '{acc: INCU_RST_BYTE, pointer_high_byte: INCU_RST_BYTE,
                       pointer_low_byte: INCU_RST_BYTE,
                       port_latch: {4{INCU_RST_PORT}}};
         cnt_reg <= '0;
         last_reg <= '0;
         tgt_reg <= '0;
         ready_reg <= 1'b1;
         done_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         cmd_reg <= cmd_next;
         arch_reg <= arch_next;
         cnt_reg <= cnt_next;
         last_reg <= last_next;
         tgt_reg <= tgt_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
         reject_reg <= reject_next;
      end
   end

   assign CMD_READY_O = ready_reg;
   assign DONE_O = done_reg;
   assign REJECT_O = reject_reg;
   assign PEEK_DATA_O = mem_rdata;
   assign ARCH_O = arch_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks: snapshot at accept, latency counter
   incu_arch_s snap_reg;
   logic [7:0] lat_reg;
   logic [7:0] ptr_seen_reg;
   logic accept;
   assign accept = state_reg == S_IDLE && CMD_VALID_I && incu_decode(CMD_I.opcode) != K_NONE;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         snap_reg <= '0;
         lat_reg <= '0;
         ptr_seen_reg <= '0;
      end else begin
         if (accept) begin
            snap_reg <= arch_reg;
         end
         lat_reg <= (state_reg == S_EXEC) ? lat_reg + 8'h01 : 8'h00;
         if (state_reg == S_EXEC && cnt_reg == STEP_PTR) begin
            ptr_seen_reg <= mem_rdata;
         end
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   property p_byte_latency;
      DONE_O && kind_reg != K_DATA_POINTER |-> lat_reg == 8'(MCYC_CLKS);
   endproperty
   a_byte_latency: assert property (p_byte_latency) else $error("byte form latency wrong"); // RULE1

   property p_acc_wrap;
      DONE_O && kind_reg == K_ACC |-> ARCH_O.acc == 8'(snap_reg.acc + 8'h01);
   endproperty
   a_acc_wrap: assert property (p_acc_wrap) else $error("accumulator increment wrong"); // RULE2

   property p_port_latch;
      DONE_O && kind_reg == K_DIR && cmd_reg.operand == INCU_ADR_PORT1
         |-> ARCH_O.port_latch[1] == 8'(snap_reg.port_latch[1] + 8'h01);
   endproperty
   a_port_latch: assert property (p_port_latch) else $error("port latch increment wrong"); // RULE3

   property p_rn_addr;
      mem_we && state_reg == S_EXEC && kind_reg == K_RN
         |-> mem_waddr == {3'h0, cmd_reg.bank, cmd_reg.opcode[2:0]};
   endproperty
   a_rn_addr: assert property (p_rn_addr) else $error("working register address wrong"); // RULE4

   property p_dir_addr;
      mem_we && state_reg == S_EXEC && kind_reg == K_DIR |-> mem_waddr == cmd_reg.operand;
   endproperty
   a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong"); // RULE5

   property p_ind_addr;
      mem_we && state_reg == S_EXEC && kind_reg == K_IND |-> mem_waddr == ptr_seen_reg;
   endproperty
   a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong"); // RULE6

   property p_data_pointer_inc;
      DONE_O && kind_reg == K_DATA_POINTER |->
         {ARCH_O.pointer_high_byte, ARCH_O.pointer_low_byte} ==
         16'({snap_reg.pointer_high_byte, snap_reg.pointer_low_byte} + 16'h0001);
   endproperty
   a_data_pointer_inc: assert property (p_data_pointer_inc) else $error("data pointer increment wrong"); // RULE7

   property p_data_pointer_carry;
      DONE_O && kind_reg == K_DATA_POINTER && snap_reg.pointer_low_byte == 8'hFF
         |-> ARCH_O.pointer_high_byte == 8'(snap_reg.pointer_high_byte + 8'h01);
   endproperty
   a_data_pointer_carry: assert property (p_data_pointer_carry) else $error("low byte carry lost"); // RULE8

   property p_data_pointer_only;
      DONE_O && kind_reg != K_DATA_POINTER && !(kind_reg == K_DIR &&
         (cmd_reg.operand == INCU_ADR_DPL || cmd_reg.operand == INCU_ADR_DPH))
         |-> ARCH_O.pointer_high_byte == snap_reg.pointer_high_byte &&
             ARCH_O.pointer_low_byte == snap_reg.pointer_low_byte;
   endproperty
   a_data_pointer_only: assert property (p_data_pointer_only) else $error("pointer touched by other form"); // RULE9

   property p_data_pointer_latency;
      DONE_O && kind_reg == K_DATA_POINTER |-> lat_reg == 8'(2 * MCYC_CLKS);
   endproperty
   a_data_pointer_latency: assert property (p_data_pointer_latency) else $error("pointer form latency wrong"); // RULE10

   property p_decode;
      accept && CMD_I.opcode == INCU_OP_DATA_POINTER |=> kind_reg == K_DATA_POINTER && last_reg == LAST_DATA_POINTER;
   endproperty
   a_decode: assert property (p_decode) else $error("pointer opcode not decoded"); // RULE11

   c_acc: cover property (DONE_O && kind_reg == K_ACC && snap_reg.acc == 8'hFF);
   c_ind: cover property (DONE_O && kind_reg == K_IND);
   c_data_pointer: cover property (DONE_O && kind_reg == K_DATA_POINTER && snap_reg.pointer_low_byte == 8'hFF);
   c_rej: cover property (REJECT_O);
endmodule // incu_unit

/* File: bench/incu_unit_tb_top.sv */
`timescale 1ns/1ps
module incu_unit_tb_top;
   import incu_pkg::*;
   localparam int MC = 4; // short machine cycle keeps the run brief

   typedef struct {
      logic [7:0] op;
      logic [7:0] opnd;
      logic [1:0] bk;
      logic [7:0] adr;
      logic [7:0] init;
      logic [7:0] exp;
   } incu_tb_row_s;

   logic CLK_I;
   logic RST_N_I;
   logic CMD_VALID_I;
   incu_cmd_s CMD_I;
   logic CMD_READY_O;
   logic DONE_O;
   logic REJECT_O;
   logic LD_VALID_I;
   logic [7:0] LD_ADDR_I;
   logic [7:0] LD_DATA_I;
   logic [7:0] PEEK_ADDR_I;
   logic [7:0] PEEK_DATA_O;
   incu_arch_s ARCH_O;
   int n_mismatch = 0;
   int checked = 0;
   logic [7:0] v;
   incu_arch_s arch0;
   incu_tb_row_s rows [11];
   logic [7:0] bad_ops [6];

   incu_unit #(.MCYC_CLKS(MC)) dut_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
      .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I), .CMD_READY_O(CMD_READY_O),
      .DONE_O(DONE_O), .REJECT_O(REJECT_O), .LD_VALID_I(LD_VALID_I),
      .LD_ADDR_I(LD_ADDR_I), .LD_DATA_I(LD_DATA_I), .PEEK_ADDR_I(PEEK_ADDR_I),
      .PEEK_DATA_O(PEEK_DATA_O), .ARCH_O(ARCH_O));

   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      CLK_I = 1'b0;
      forever #25 CLK_I = ~CLK_I;
   end

   // comparison and verdict
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // bus tasks: entered at a falling edge, left at a falling edge
   // load ends one cycle late so the strobe is low for a cycle before a following load raises it again
   task automatic load(input logic [7:0] a, input logic [7:0] d);
      LD_VALID_I = 1'b1;
      LD_ADDR_I = a;
      LD_DATA_I = d;
      @(negedge CLK_I);
      LD_VALID_I = 1'b0;
      @(negedge CLK_I);
   endtask

   // ram through the peek port, special registers straight off the state bus
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      if (a < 8'h80) begin
         PEEK_ADDR_I = a;
         @(negedge CLK_I);
         d = PEEK_DATA_O;
      end else begin
         case (a)
            8'hE0: d = ARCH_O.acc;
            8'h82: d = ARCH_O.pointer_low_byte;
            8'h83: d = ARCH_O.pointer_high_byte;
            default: d = ARCH_O.port_latch[a[5:4]];
         endcase
      end
   endtask

   // issue one instruction and time it to completion in clock cycles
   task automatic issue(input logic [7:0] op, input logic [7:0] opnd, input logic [1:0] bk,
                        input int exp_n);
      int n;
      CMD_VALID_I = 1'b1;
      CMD_I = '{opcode: op, operand: opnd, bank: bk};
      @(negedge CLK_I);
      CMD_VALID_I = 1'b0;
      n = 1;
      check("ready_busy", CMD_READY_O, 1'b0);
      while (DONE_O !== 1'b1 && n < 60) begin
         @(negedge CLK_I);
         n++;
      end
      check("cycles", n, exp_n);
      check("ready_done", CMD_READY_O, 1'b1);
   endtask

   task automatic reject(input logic [7:0] op);
      CMD_VALID_I = 1'b1;
      CMD_I = '{opcode: op, operand: 8'h30, bank: 2'h0};
      @(negedge CLK_I);
      CMD_VALID_I = 1'b0;
      check("reject", REJECT_O, 1'b1);
      @(negedge CLK_I);
      check("reject_end", REJECT_O, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under two thousand cycles
   initial begin
      #(50 * 5000);
      n_mismatch++;
      $display("[ERR] watchdog expected finish seen hang");
      complete_run();
   end

   // main sequence
   initial begin
      RST_N_I = 1'b0;
      CMD_VALID_I = 1'b0;
      CMD_I = '0;
      LD_VALID_I = 1'b0;
      LD_ADDR_I = 8'h00;
      LD_DATA_I = 8'h00;
      PEEK_ADDR_I = 8'h00;
      rows = '{'{8'h04, 8'h00, 2'h0, 8'hE0, 8'h7F, 8'h80},
               '{8'h04, 8'h00, 2'h0, 8'hE0, 8'hFF, 8'h00},
               '{8'h08, 8'h00, 2'h0, 8'h00, 8'h10, 8'h11},
               '{8'h0F, 8'h00, 2'h3, 8'h1F, 8'hFF, 8'h00},
               '{8'h0C, 8'h00, 2'h2, 8'h14, 8'h41, 8'h42},
               '{8'h05, 8'h30, 2'h0, 8'h30, 8'h7E, 8'h7F},
               '{8'h05, 8'h7F, 2'h0, 8'h7F, 8'hFF, 8'h00},
               '{8'h05, 8'h90, 2'h0, 8'h90, 8'h5A, 8'h5B},
               '{8'h05, 8'hB0, 2'h0, 8'hB0, 8'hFF, 8'h00},
               '{8'h05, 8'hE0, 2'h0, 8'hE0, 8'h3C, 8'h3D},
               '{8'h05, 8'h83, 2'h0, 8'h83, 8'h07, 8'h08}};
      repeat (4) @(negedge CLK_I);
      check("rst_arch", ARCH_O, {24'h000000, 32'hFFFFFFFF});
      check("rst_flags", {CMD_READY_O, DONE_O, REJECT_O}, 3'b100);
      RST_N_I = 1'b1;
      @(negedge CLK_I);
      // port latch straight from reset: latch value used, never the pins
      issue(8'h05, 8'hA0, 2'h0, MC + 1);
      check("port2", ARCH_O.port_latch[2], 8'h00);
      $display("test reset done");

      // table of byte forms
      foreach (rows[i]) begin
         load(rows[i].adr, rows[i].init);
         issue(rows[i].op, rows[i].opnd, rows[i].bk, MC + 1);
         rd(rows[i].adr, v);
         check("row", v, rows[i].exp);
      end
      $display("test rows done");

      // every working register of bank 1
      for (int r = 0; r < 8; r++) begin
         load(8'h08 + 8'(r), 8'(r * 16 + 5));
         issue(8'h08 | 8'(r), 8'h00, 2'h1, MC + 1);
         rd(8'h08 + 8'(r), v);
         check("wreg", v, 8'(r * 16 + 6));
      end
      $display("test working registers done");

      // indirect through pointer register 0, then pointer register 1 of bank 1
      load(8'h00, 8'h7E);
      load(8'h7E, 8'hFF);
      load(8'h7F, 8'h40);
      issue(8'h06, 8'h00, 2'h0, MC + 1);
      issue(8'h08, 8'h00, 2'h0, MC + 1);
      issue(8'h06, 8'h00, 2'h0, MC + 1);
      rd(8'h00, v);
      check("ptr0", v, 8'h7F);
      rd(8'h7E, v);
      check("ind_7e", v, 8'h00);
      rd(8'h7F, v);
      check("ind_7f", v, 8'h41);
      load(8'h09, 8'h20);
      load(8'h20, 8'h33);
      issue(8'h07, 8'h00, 2'h1, MC + 1);
      rd(8'h20, v);
      check("ind_r1", v, 8'h34);
      rd(8'h09, v);
      check("ptr1_kept", v, 8'h20);
      $display("test indirect done");

      // data pointer: three back to back, then full wrap
      load(8'h83, 8'h12);
      load(8'h82, 8'hFE);
      repeat (3) issue(8'hA3, 8'h00, 2'h0, 2 * MC + 1);
      check("data_pointer", {ARCH_O.pointer_high_byte, ARCH_O.pointer_low_byte}, 16'h1301);
      load(8'h83, 8'hFF);
      load(8'h82, 8'hFF);
      issue(8'hA3, 8'h00, 2'h0, 2 * MC + 1);
      check("data_pointer_wrap", {ARCH_O.pointer_high_byte, ARCH_O.pointer_low_byte}, 16'h0000);
      // a byte increment of the low half must not carry
      load(8'h83, 8'h55);
      load(8'h82, 8'hFF);
      issue(8'h05, 8'h82, 2'h0, MC + 1);
      check("low_only", {ARCH_O.pointer_high_byte, ARCH_O.pointer_low_byte}, 16'h5500);
      $display("test data pointer done");

      // opcodes outside the increment group change nothing
      // neighbours of the increment group that must not decode as one
      bad_ops = '{8'h00, 8'h14, 8'hA4, 8'h15, 8'hA5, 8'h03};
      foreach (bad_ops[k]) begin
         arch0 = ARCH_O;
         reject(bad_ops[k]);
         check("reject_arch", ARCH_O, arch0);
      end
      $display("test reject done");

      // reset in mid instruction
      CMD_VALID_I = 1'b1;
      CMD_I = '{opcode: 8'hA3, operand: 8'h00, bank: 2'h0};
      @(negedge CLK_I);
      CMD_VALID_I = 1'b0;
      @(negedge CLK_I);
      RST_N_I = 1'b0;
      @(negedge CLK_I);
      check("rst2_arch", ARCH_O, {24'h000000, 32'hFFFFFFFF});
      check("rst2_flags", {CMD_READY_O, DONE_O, REJECT_O}, 3'b100);
      RST_N_I = 1'b1;
      @(negedge CLK_I);
      issue(8'h04, 8'h00, 2'h0, MC + 1);
      check("acc_after", ARCH_O.acc, 8'h01);
      $display("test mid reset done");
      complete_run();
   end
endmodule // incu_unit_tb_top
